// file: pkg/locality_pkg.sv
// Contract
// - Successful seize clears the grant of every lower-priority active locality.
// - Seize never touches the request flag of localities other than the seizer.
// - Seize grants the seizer, drops its request, clears waiting flags if none remain.
// - Successful seize aborts the running command.
// - Seize from equal or lower priority than the owner is ignored.
// - Seize field always reads zero.
// - A new request sets the waiting flag of every other locality.
// - Grant with no requests left clears the waiting flag of all others.
// - Cancel: none left clears all, one left clears its copy, several none.
// - Waiting flag is read-only; host writes to it are dropped.
// - Writing one sets the request flag; repeats while set are ignored.
// - Being granted clears that locality's request flag.
// - Cancel by writing the grant bit clears the request flag.
// - Zero writes to the request flag do nothing.
// - Launch flag reads true value when fields valid, else never a false one.
// - Launch flag reads one until a launch hash finish clears it promptly.
// - Cleared launch flag stays zero until restore; held non-volatile.
// - One launch flag value shown to every locality.
// - Status writes with more than one field set are ignored whole.
// - Reception starts at first command byte after Ready, ends on execute.
// - Execution until response pending unless aborted, Completion until ready write.
// - Idle after completion plus ready write, locality change, abort or init.
// - Ready state exactly when the ready control reads one.
// - On relinquish the highest pending requester is granted.
// - Seize sets the loser's ownership-lost flag; writing one clears it.
// - Restore from locality 3 or 4 in Ready or Idle sets launch flag.
package locality_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_LOC = 5;
  localparam int LOC_W = 3;
  localparam int ACC_W = 8;
  localparam int STS_W = 32;

  // ----------------------------------------
  // Access register fields
  // ----------------------------------------
  localparam int ACC_LAUNCH_BIT = 0;
  localparam int ACC_REQ_BIT = 1;
  localparam int ACC_WAIT_BIT = 2;
  localparam int ACC_SEIZE_BIT = 3;
  localparam int ACC_LOST_BIT = 4;
  localparam int ACC_GRANT_BIT = 5;
  localparam int ACC_VALID_BIT = 7;

  // ----------------------------------------
  // Status register fields
  // ----------------------------------------
  localparam int STS_RESTORE_BIT = 25;
  localparam int STS_CANCEL_BIT = 24;
  localparam int STS_VALID_BIT = 7;
  localparam int STS_READY_BIT = 6;
  localparam int STS_GO_BIT = 5;
  localparam int STS_RESP_BIT = 4;
  localparam int STS_RETRY_BIT = 1;

  localparam logic [LOC_W-1:0] LOC_RESTORE_MIN = 3'h3;

  typedef logic [NUM_LOC-1:0] loc_vec_t;
  typedef logic [LOC_W-1:0] loc_idx_t;

  typedef enum logic [2:0] {
    CMD_IDLE = 3'b000,
    CMD_READY = 3'b001,
    CMD_RECEPTION = 3'b010,
    CMD_EXECUTION = 3'b011,
    CMD_COMPLETION = 3'b100
  } cmd_state_t;

endpackage

// file: pkg/cmd_ctl_if.sv
`timescale 1ns/1ps
interface cmd_ctl_if;
  import locality_pkg::*;
  logic ready_wr;
  logic go_wr;
  logic first_byte;
  logic done;
  logic abort;
  cmd_state_t state;

  modport arb (output ready_wr, output go_wr, output first_byte, output done,
               output abort, input state);
  modport fsm (input ready_wr, input go_wr, input first_byte, input done,
               input abort, output state);
endinterface

// file: hdl/cmd_state_machine.sv
`timescale 1ns/1ps
module cmd_state_machine (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Strobes from the arbiter
  cmd_ctl_if.fsm ctl
);
  import locality_pkg::*;

  cmd_state_t state_reg;
  cmd_state_t state_next;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    if (ctl.abort) begin
      state_next = CMD_IDLE;
    end else begin
      case (state_reg)
        CMD_IDLE: begin
          if (ctl.ready_wr) begin
            state_next = CMD_READY;
          end
        end
        CMD_READY: begin
          if (ctl.first_byte) begin
            state_next = CMD_RECEPTION;
          end
        end
        CMD_RECEPTION: begin
          // A ready write mid-command doubles as an abort
          if (ctl.ready_wr) begin
            state_next = CMD_IDLE;
          end else if (ctl.go_wr) begin
            state_next = CMD_EXECUTION;
          end
        end
        CMD_EXECUTION: begin
          if (ctl.ready_wr) begin
            state_next = CMD_IDLE;
          end else if (ctl.done) begin
            state_next = CMD_COMPLETION;
          end
        end
        CMD_COMPLETION: begin
          if (ctl.ready_wr) begin
            state_next = CMD_IDLE;
          end
        end
        default: begin
          state_next = CMD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_reg <= CMD_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign ctl.state = state_reg;

endmodule

// file: hdl/locality_arbiter.sv
`timescale 1ns/1ps
module locality_arbiter (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Host register cycles
  input wire logic acc_wr_i,
  input wire logic sts_wr_i,
  input wire logic rd_i,
  input wire logic rd_sts_sel_i,
  input wire logic [locality_pkg::LOC_W-1:0] loc_i,
  input wire logic [locality_pkg::STS_W-1:0] wdata_i,
  output logic [locality_pkg::STS_W-1:0] rdata_o,
  // Command core
  input wire logic first_byte_i,
  input wire logic cmd_done_i,
  output logic cmd_abort_o,
  output locality_pkg::cmd_state_t cmd_state_o,
  // Ownership
  output logic [locality_pkg::LOC_W-1:0] active_loc_o,
  output logic loc_active_o,
  // Dynamic launch flag and its non-volatile store
  input wire logic hash_finish_i,
  input wire logic nv_launch_i,
  output logic launch_absent_o
);
  import locality_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic loc_vec_t loc_bit(input loc_idx_t idx);
    loc_vec_t v;
    v = '0;
    if (idx < loc_idx_t'(NUM_LOC)) begin
      v[idx] = 1'b1;
    end
    return v;
  endfunction

  // Highest set index wins: priority rises with locality number
  function automatic loc_idx_t top_loc(input loc_vec_t v);
    loc_idx_t idx;
    idx = '0;
    for (int i = 0; i < NUM_LOC; i++) begin
      if (v[i]) begin
        idx = loc_idx_t'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic one_set(input loc_vec_t v);
    return (v != '0) && ((v & loc_vec_t'(v - 1'b1)) == '0);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  loc_vec_t grant_reg;
  loc_vec_t grant_next;
  loc_vec_t req_reg;
  loc_vec_t req_next;
  loc_vec_t wait_reg;
  loc_vec_t wait_next;
  loc_vec_t lost_reg;
  loc_vec_t lost_next;
  logic launch_reg;
  logic valid_reg;
  logic abort_reg;
  logic abort_next;
  logic ready_wr_reg;
  logic go_wr_reg;
  logic first_byte_reg;
  logic done_reg;
  logic [STS_W-1:0] rdata_reg;
  logic [STS_W-1:0] rdata_next;
  loc_idx_t active_reg;
  logic any_active_reg;

  cmd_ctl_if ctl ();

  cmd_state_machine u_fsm (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .ctl(ctl.fsm)
  );

  // ----------------------------------------
  // Decode of the current cycle
  // ----------------------------------------
  wire loc_ok = loc_i < loc_idx_t'(NUM_LOC);
  wire loc_vec_t wr_bit = loc_bit(loc_i);
  wire any_active = |grant_reg;
  wire loc_idx_t active_idx = top_loc(grant_reg);
  wire is_owner = |(grant_reg & wr_bit);
  wire has_req = |(req_reg & wr_bit);
  wire acc_wr = acc_wr_i && loc_ok;

  // Seize from the owner's level or below does nothing
  wire seize_ok = acc_wr && wdata_i[ACC_SEIZE_BIT] &&
                  (!any_active || (loc_i > active_idx));
  wire relinquish = acc_wr && wdata_i[ACC_GRANT_BIT] && is_owner;
  wire cancel = acc_wr && wdata_i[ACC_GRANT_BIT] && !is_owner && has_req;
  // Zero writes and repeats are filtered here
  wire request_new = acc_wr && wdata_i[ACC_REQ_BIT] && !has_req && !is_owner;
  wire lost_clr = acc_wr && wdata_i[ACC_LOST_BIT];
  wire loc_vec_t other_req = req_reg & ~wr_bit;

  // ----------------------------------------
  // Status write decode
  // ----------------------------------------
  wire [4:0] sts_fields = {wdata_i[STS_RESTORE_BIT], wdata_i[STS_CANCEL_BIT],
                           wdata_i[STS_READY_BIT], wdata_i[STS_GO_BIT],
                           wdata_i[STS_RETRY_BIT]};
  wire sts_single = one_set(sts_fields);
  wire sts_wr = sts_wr_i && loc_ok && sts_single;
  wire ready_wr = sts_wr && is_owner && wdata_i[STS_READY_BIT];
  wire go_wr = sts_wr && is_owner && wdata_i[STS_GO_BIT];
  wire idle_or_ready = (ctl.state == CMD_IDLE) || (ctl.state == CMD_READY);
  // Lower localities may not restore the launch flag
  wire restore_ok = sts_wr && wdata_i[STS_RESTORE_BIT] &&
                    (loc_i >= LOC_RESTORE_MIN) && idle_or_ready;

  // ----------------------------------------
  // Ownership arbitration
  // ----------------------------------------
  // Writes are applied first, then a free device hands ownership to the
  // best requester in the same cycle, so relinquish and grant never gap.
  always_comb begin
    grant_next = grant_reg;
    req_next = req_reg;
    wait_next = wait_reg;
    lost_next = lost_reg;
    abort_next = 1'b0;
    if (lost_clr) begin
      lost_next = lost_next & ~wr_bit;
    end
    if (seize_ok) begin
      grant_next = wr_bit;
      req_next = req_reg & ~wr_bit;
      if (other_req == '0) begin
        wait_next = '0;
      end
      // Set wins over a clear of the same cycle
      lost_next = lost_next | grant_reg;
      abort_next = 1'b1;
    end else if (relinquish) begin
      grant_next = '0;
    end else if (cancel) begin
      req_next = other_req;
      if (other_req == '0) begin
        wait_next = '0;
      end else if (one_set(other_req)) begin
        wait_next = wait_reg & ~other_req;
      end
    end else if (request_new) begin
      req_next = req_reg | wr_bit;
      wait_next = wait_reg | ~wr_bit;
    end
    if ((grant_next == '0) && (req_next != '0)) begin
      grant_next = loc_bit(top_loc(req_next));
      req_next = req_next & ~grant_next;
      if (req_next == '0) begin
        wait_next = '0;
      end
    end
    // A change of owner drops any command in flight
    if (grant_next != grant_reg) begin
      abort_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      grant_reg <= '0;
    end else begin
      grant_reg <= grant_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      req_reg <= '0;
    end else begin
      req_reg <= req_next;
    end
  end

  // Host writes never reach the waiting flags directly
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wait_reg <= '0;
    end else begin
      wait_reg <= wait_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      lost_reg <= '0;
    end else begin
      lost_reg <= lost_next;
    end
  end

  // ----------------------------------------
  // Command strobes
  // ----------------------------------------
  // Registered so the state machine sees one clean pulse per event
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      abort_reg <= 1'b0;
    end else begin
      abort_reg <= abort_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ready_wr_reg <= 1'b0;
    end else begin
      ready_wr_reg <= ready_wr;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      go_wr_reg <= 1'b0;
    end else begin
      go_wr_reg <= go_wr;
    end
  end

  // The command core runs on this clock, so its strobes need no synchroniser
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      first_byte_reg <= 1'b0;
    end else begin
      first_byte_reg <= first_byte_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= cmd_done_i;
    end
  end

  assign ctl.abort = abort_reg;
  assign ctl.ready_wr = ready_wr_reg;
  assign ctl.go_wr = go_wr_reg;
  assign ctl.first_byte = first_byte_reg;
  assign ctl.done = done_reg;

  // ----------------------------------------
  // Dynamic launch flag
  // ----------------------------------------
  // Not cleared by reset: it reloads the non-volatile copy instead, and
  // the store keeps launch_absent_o written back after every change.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      launch_reg <= nv_launch_i;
    end else if (hash_finish_i) begin
      launch_reg <= 1'b0;
    end else if (restore_ok) begin
      launch_reg <= 1'b1;
    end
  end

  // Fields become trustworthy one cycle after reset, once the
  // non-volatile copy has landed
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= 1'b1;
    end
  end

  // Shows zero while unsure, so a false "not launched" never escapes
  wire launch_shown = valid_reg && launch_reg;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  wire [ACC_W-1:0] acc_word = {valid_reg, 1'b0,
                               |(grant_reg & wr_bit),
                               |(lost_reg & wr_bit),
                               1'b0,
                               |(wait_reg & wr_bit),
                               |(req_reg & wr_bit),
                               launch_shown};

  always_comb begin
    rdata_next = '0;
    if (rd_i && loc_ok) begin
      if (rd_sts_sel_i) begin
        rdata_next[STS_VALID_BIT] = valid_reg;
        rdata_next[STS_READY_BIT] = (ctl.state == CMD_READY);
        rdata_next[STS_RESP_BIT] = (ctl.state == CMD_COMPLETION);
      end else begin
        rdata_next[ACC_W-1:0] = acc_word;
      end
    end
  end

  // Read data lags the read strobe by one cycle
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Owner outputs track the next grant so they line up with the flags
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      active_reg <= '0;
    end else begin
      active_reg <= top_loc(grant_next);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      any_active_reg <= 1'b0;
    end else begin
      any_active_reg <= |grant_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata_o = rdata_reg;
  assign cmd_abort_o = abort_reg;
  assign cmd_state_o = ctl.state;
  assign active_loc_o = active_reg;
  assign loc_active_o = any_active_reg;
  assign launch_absent_o = launch_reg;

endmodule

// file: sim/locality_arbiter_properties.sv
`timescale 1ns/1ps
module locality_arbiter_properties (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Host cycles
  input wire logic acc_wr_i,
  input wire logic sts_wr_i,
  input wire logic rd_i,
  input wire logic rd_sts_sel_i,
  input wire logic [locality_pkg::LOC_W-1:0] loc_i,
  input wire logic [locality_pkg::STS_W-1:0] wdata_i,
  input wire logic [locality_pkg::STS_W-1:0] rdata_o,
  // Core, owner and launch flag
  input wire logic hash_finish_i,
  input wire logic cmd_abort_o,
  input wire locality_pkg::cmd_state_t cmd_state_o,
  input wire logic [locality_pkg::LOC_W-1:0] active_loc_o,
  input wire logic loc_active_o,
  input wire logic launch_absent_o
);
  import locality_pkg::*;
  // --------
  // Checks
  // --------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  wire logic acc_rd = rd_i && !rd_sts_sel_i && loc_i < 3'h5;
  wire logic seize = acc_wr_i && wdata_i[ACC_SEIZE_BIT] && loc_active_o;
  init_idle_a: assert property ($fell(reset_i) |-> cmd_state_o == CMD_IDLE && !loc_active_o)
    else $error("state not idle after reset");
  abort_idle_a: assert property (cmd_abort_o |=> cmd_state_o == CMD_IDLE)
    else $error("abort did not reach idle");
  seize_win_a: assert property (seize && loc_i < 3'h5 && loc_i > active_loc_o
    |=> active_loc_o == $past(loc_i) && cmd_abort_o) else $error("seize not granted");
  seize_drop_a: assert property (seize && wdata_i[7:0] == 8'h08 && loc_i <= active_loc_o
    |=> loc_active_o && $stable(active_loc_o)) else $error("weak seize took effect");
  hash_clear_a: assert property (hash_finish_i |=> !launch_absent_o)
    else $error("launch flag not cleared");
  flag_fall_a: assert property ($fell(launch_absent_o) |-> $past(hash_finish_i))
    else $error("launch flag fell alone");
  flag_rise_a: assert property ($rose(launch_absent_o) |-> $past(sts_wr_i &&
    wdata_i[STS_RESTORE_BIT] && loc_i inside {3'h3, 3'h4})) else $error("bad restore");
  recv_entry_a: assert property ($changed(cmd_state_o) && cmd_state_o == CMD_RECEPTION
    |-> $past(cmd_state_o) == CMD_READY) else $error("reception not from ready");
  comp_exit_a: assert property ($past(cmd_state_o) == CMD_COMPLETION
    && cmd_state_o != CMD_COMPLETION |-> cmd_state_o == CMD_IDLE) else $error("bad exit");
  read_bits_a: assert property ($past(acc_rd) |-> !rdata_o[ACC_SEIZE_BIT]
    && !(rdata_o[ACC_REQ_BIT] && rdata_o[ACC_GRANT_BIT])) else $error("bad access bits");
  read_flag_a: assert property ($past(acc_rd) && rdata_o[ACC_VALID_BIT]
    |-> rdata_o[ACC_LAUNCH_BIT] == $past(launch_absent_o)) else $error("bad launch bit");
  cover property (cmd_state_o == CMD_COMPLETION);
  cover property (seize && loc_i > active_loc_o);
  cover property ($fell(launch_absent_o));
endmodule

bind locality_arbiter locality_arbiter_properties chk (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .acc_wr_i(acc_wr_i), .sts_wr_i(sts_wr_i),
  .rd_i(rd_i), .rd_sts_sel_i(rd_sts_sel_i), .loc_i(loc_i), .wdata_i(wdata_i),
  .rdata_o(rdata_o), .hash_finish_i(hash_finish_i), .cmd_abort_o(cmd_abort_o),
  .cmd_state_o(cmd_state_o), .active_loc_o(active_loc_o), .loc_active_o(loc_active_o),
  .launch_absent_o(launch_absent_o)
);

// file: sim/host_model.sv
`timescale 1ns/1ps
module host_model (
  // Clock and read data
  input wire logic core_clk_i,
  input wire logic [31:0] rdata_i,
  // Register cycle
  output logic acc_wr_o,
  output logic sts_wr_o,
  output logic rd_o,
  output logic rd_sts_sel_o,
  output logic [2:0] loc_o,
  output logic [31:0] wdata_o
);
  // --------
  // Register cycles
  // --------
  initial {acc_wr_o, sts_wr_o, rd_o, rd_sts_sel_o, loc_o, wdata_o} = '0;
  // One cycle per call, idle between; status writes carry one field unless a test says so
  task automatic cyc(input logic [3:0] k, input logic [2:0] l, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge core_clk_i);
    #1;
    {acc_wr_o, sts_wr_o, rd_o, rd_sts_sel_o, loc_o, wdata_o} = {k, l, d};
    @(posedge core_clk_i);
    #1;
    {acc_wr_o, sts_wr_o, rd_o, rd_sts_sel_o} = 4'h0;
    // Idle bus shows the inverse so an unqualified decode would misfire
    loc_o = ~l;
    wdata_o = ~d;
    q = rdata_i;
  endtask
endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import locality_pkg::*;
  logic clk = 1'b0;
  logic reset;
  logic nv;
  logic [2:0] ev = 3'h0;
  logic acc_wr, sts_wr, rd, rd_sel, abort, loc_active, launch;
  logic [2:0] loc, owner;
  logic [31:0] wdata, rdata, q;
  cmd_state_t state;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  host_model host (.core_clk_i(clk), .rdata_i(rdata), .acc_wr_o(acc_wr), .sts_wr_o(sts_wr),
    .rd_o(rd), .rd_sts_sel_o(rd_sel), .loc_o(loc), .wdata_o(wdata));

  locality_arbiter dut (.core_clk_i(clk), .reset_i(reset), .acc_wr_i(acc_wr),
    .sts_wr_i(sts_wr), .rd_i(rd), .rd_sts_sel_i(rd_sel), .loc_i(loc), .wdata_i(wdata),
    .rdata_o(rdata), .first_byte_i(ev[0]), .cmd_done_i(ev[1]), .cmd_abort_o(abort),
    .cmd_state_o(state), .active_loc_o(owner), .loc_active_o(loc_active),
    .hash_finish_i(ev[2]), .nv_launch_i(nv), .launch_absent_o(launch));

  // --------
  // Helpers
  // --------
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wa(input logic [2:0] l, input logic [7:0] d);
    host.cyc(4'h8, l, {24'h0, d}, q);
  endtask
  task automatic ws(input logic [2:0] l, input logic [31:0] d);
    host.cyc(4'h4, l, d, q);
  endtask
  task automatic ra(input logic [2:0] l, input logic [7:0] e);
    host.cyc(4'h2, l, 32'h0, q);
    chk("access", q, {24'h0, e});
  endtask
  task automatic rs(input logic [2:0] l, input logic [31:0] e);
    host.cyc(4'h3, l, 32'h0, q);
    chk("status", q, e);
  endtask
  // Bounded wait: the state lands two edges after its cause
  task automatic st(input cmd_state_t e);
    for (int k = 0; k < 6 && state !== e; k++) begin
      @(posedge clk);
      #1;
    end
    chk("state", 32'(state), 32'(e));
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    #1;
    ev[i] = 1'b1;
    @(posedge clk);
    #1;
    ev[i] = 1'b0;
  endtask
  task automatic rst(input logic v);
    nv = v;
    reset = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    reset = 1'b0;
  endtask
  task automatic done(input string n);
    $display("test %s done", n);
  endtask
  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      results();
    end
  end

  // --------
  // Tests
  // --------
  initial begin
    rst(1'b1);
    chk("state", 32'(state), 32'(CMD_IDLE));
    chk("launch", 32'(launch), 32'h1);
    wa(1, 8'h02);
    chk("abort", 32'(abort), 32'h1);
    ra(1, 8'ha1);
    ra(0, 8'h81);
    wa(0, 8'h02);
    wa(0, 8'h02);
    wa(0, 8'h00);
    wa(4, 8'h04);
    ra(0, 8'h83);
    ra(4, 8'h85);
    wa(2, 8'h02);
    wa(1, 8'h20);
    chk("owner", 32'(owner), 32'h2);
    chk("active", 32'(loc_active), 32'h1);
    ra(2, 8'ha5);
    ra(0, 8'h87);
    wa(0, 8'h20);
    ra(0, 8'h81);
    ra(2, 8'ha1);
    wa(0, 8'h02);
    wa(1, 8'h02);
    wa(0, 8'h20);
    ra(1, 8'h83);
    ra(0, 8'h85);
    done("ownership");
    ws(2, 32'h40);
    st(CMD_READY);
    rs(2, 32'hc0);
    pulse(0);
    st(CMD_RECEPTION);
    ws(2, 32'h20);
    st(CMD_EXECUTION);
    ws(2, 32'h60);
    repeat (3) @(posedge clk);
    st(CMD_EXECUTION);
    pulse(1);
    st(CMD_COMPLETION);
    rs(2, 32'h90);
    ws(2, 32'h40);
    st(CMD_IDLE);
    ws(2, 32'h40);
    st(CMD_READY);
    pulse(0);
    st(CMD_RECEPTION);
    wa(4, 8'h08);
    chk("abort", 32'(abort), 32'h1);
    st(CMD_IDLE);
    chk("owner", 32'(owner), 32'h4);
    ra(2, 8'h95);
    ra(1, 8'h83);
    ra(4, 8'ha5);
    wa(2, 8'h10);
    ra(2, 8'h85);
    wa(3, 8'h08);
    chk("abort", 32'(abort), 32'h0);
    chk("owner", 32'(owner), 32'h4);
    chk("active", 32'(loc_active), 32'h1);
    done("seize");
    pulse(2);
    chk("launch", 32'(launch), 32'h0);
    ra(0, 8'h84);
    rst(launch);
    chk("launch", 32'(launch), 32'h0);
    ra(0, 8'h80);
    ws(1, 32'h0200_0000);
    ra(0, 8'h80);
    ws(4, 32'h0200_0000);
    chk("launch", 32'(launch), 32'h1);
    ra(0, 8'h81);
    done("launch");
    results();
  end
endmodule
